// *** verilog/bcmae_core.v ***
// instruction decode and execute core for byte/word moves and byte arithmetic
// Functional notes
// - selectors 0..7: X, A, C, B, E, D, L, H
// - pair selectors 0..3: AX, BC, DE, HL
// - short direct byte reaches FE20H..FF1FH only
// - short direct word: same window, even only
// - absolute address full space; word transfers even
// - immediates 8/16 bits; bit operands 3 bits
// - A 8 bits; AX is X low, A high
// - pair halves reachable separately
// - only result-marked flags change
// - add into A, carry updated
// - add with carry into A
// - subtract, borrow into carry flag
// - short direct plus immediate, written back
// - exchange A with HL-plus-offset byte
// - load A from HL-plus-offset byte
// - store A to HL-plus-offset, flags kept
`timescale 1ns/1ps
`default_nettype none
`include "bcmae_consts.vh"

module bcmae_core (
  input  wire        clk,
  input  wire        reset,
  output reg  [15:0] pm_addr,
  input  wire [7:0]  pm_rdata,
  output reg  [15:0] dm_addr,
  output reg         dm_rd,
  output reg         dm_wr,
  output reg  [7:0]  dm_wdata,
  input  wire [7:0]  dm_rdata,
  output reg         instr_done,
  output reg         bad_opcode,
  output wire [15:0] word_accumulator_pair,
  output reg  [7:0]  program_status_word
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [7:0]  regs [0:7];
  reg [15:0] pc;
  reg [3:0]  cyc;
  reg [7:0]  opcode;
  reg [7:0]  b1;
  reg [7:0]  b2;
  integer    i;

  ////////////////////////////////////////////////////////////////////////////
  // decode functions

  // {legal, bytes, clocks}
  function [6:0] op_info;
    input [7:0] op;
    begin
      op_info = {1'b0, `BCMAE_B1, `BCMAE_C2};
      case (op[7:5])
        `BCMAE_GRP_TO_A, `BCMAE_GRP_FROM_A: begin
          case (op[2:0])
            `BCMAE_M_IMM:                op_info = {1'b1, `BCMAE_B3, `BCMAE_C6};
            `BCMAE_M_ABS:                op_info = {1'b1, `BCMAE_B3, `BCMAE_C8};
            `BCMAE_M_DE, `BCMAE_M_HL:    op_info = {1'b1, `BCMAE_B1, `BCMAE_C6};
            `BCMAE_M_HLB:                op_info = {1'b1, `BCMAE_B2, `BCMAE_C6};
            default:                     op_info = {1'b1, `BCMAE_B2, `BCMAE_C4};
          endcase
        end
        `BCMAE_GRP_XCH: begin
          case (op[2:0])
            `BCMAE_M_IMM:                op_info = {1'b1, `BCMAE_B1, `BCMAE_C4};
            `BCMAE_M_REG, `BCMAE_M_SADDR: op_info = {1'b1, `BCMAE_B2, `BCMAE_C6};
            `BCMAE_M_DE, `BCMAE_M_HL:    op_info = {1'b1, `BCMAE_B1, `BCMAE_C8};
            `BCMAE_M_HLB:                op_info = {1'b1, `BCMAE_B2, `BCMAE_C8};
            default:                     op_info = {1'b0, `BCMAE_B1, `BCMAE_C2};
          endcase
        end
        `BCMAE_GRP_ADD, `BCMAE_GRP_ADD_WITH_CARRY, `BCMAE_GRP_SUB: begin
          case (op[2:0])
            `BCMAE_M_ABS:                op_info = {1'b1, `BCMAE_B3, `BCMAE_C8};
            `BCMAE_M_DE:                 op_info = {1'b1, `BCMAE_B3, `BCMAE_C6};
            `BCMAE_M_HL:                 op_info = {1'b1, `BCMAE_B1, `BCMAE_C6};
            `BCMAE_M_HLB:                op_info = {1'b1, `BCMAE_B2, `BCMAE_C6};
            `BCMAE_M_PSW:                op_info = {1'b0, `BCMAE_B1, `BCMAE_C2};
            default:                     op_info = {1'b1, `BCMAE_B2, `BCMAE_C4};
          endcase
        end
        `BCMAE_GRP_WORD: begin
          case (op[2:0])
            `BCMAE_W_IMM:                op_info = {1'b1, `BCMAE_B3, `BCMAE_C6};
            `BCMAE_W_LD:                 op_info = {1'b1, `BCMAE_B2, `BCMAE_C6};
            `BCMAE_W_ST:                 op_info = {1'b1, `BCMAE_B2, `BCMAE_C8};
            `BCMAE_W_FROM, `BCMAE_W_TO:  op_info = {1'b1, `BCMAE_B1, `BCMAE_C4};
            `BCMAE_W_XCH:                op_info = {1'b1, `BCMAE_B1, `BCMAE_C8};
            default:                     op_info = {1'b0, `BCMAE_B1, `BCMAE_C2};
          endcase
        end
        default: begin
          if (op == `BCMAE_OP_PSW_IMM)
            op_info = {1'b1, `BCMAE_B3, `BCMAE_C6};
          else if (op == `BCMAE_OP_NOP)
            op_info = {1'b1, `BCMAE_B1, `BCMAE_C2};
          else
            op_info = {1'b0, `BCMAE_B1, `BCMAE_C2};
        end
      endcase
    end
  endfunction

  // one offset byte lands in the window by construction, so nothing outside it is reachable
  function [15:0] saddr_map;
    input [7:0] off;
    begin
      saddr_map = (off < `BCMAE_SADDR_SPLIT) ? {`BCMAE_SADDR_HIPG, off}
                                             : {`BCMAE_SADDR_LOPG, off};
    end
  endfunction

  // pair n is {reg 2n+1, reg 2n}
  function [15:0] pair_rd;
    input [1:0] rp;
    begin
      pair_rd = {regs[{rp, 1'b1}], regs[{rp, 1'b0}]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // combinational decode

  // a two-clock instruction must be recognised before its opcode is latched
  wire [7:0]  cur_op  = (cyc == `BCMAE_CYC_OPC) ? pm_rdata : opcode;
  wire [6:0]  info    = op_info(cur_op);
  wire        legal   = info[6];
  wire [1:0]  nbytes  = info[5:4];
  wire [3:0]  nclocks = info[3:0];
  wire        last    = (cyc == nclocks - 4'h1);
  wire [2:0]  grp     = opcode[7:5];
  wire [2:0]  mode    = opcode[2:0];
  wire [1:0]  rps     = opcode[4:3];
  wire        is_word = (grp == `BCMAE_GRP_WORD);
  wire        is_alu  = (grp == `BCMAE_GRP_ADD) || (grp == `BCMAE_GRP_ADD_WITH_CARRY) || (grp == `BCMAE_GRP_SUB);
  wire        long3   = (nbytes == `BCMAE_B3);
  wire [3:0]  t_iss   = long3 ? `BCMAE_CYC_B2 : `BCMAE_CYC_B1;
  wire [3:0]  t_exe   = t_iss + 4'h1;
  wire [7:0]  sa_byte = long3 ? b1 : pm_rdata;
  wire [7:0]  imm     = long3 ? b2 : b1;
  wire [2:0]  rsel    = b1[2:0];
  wire [7:0]  acc     = regs[`BCMAE_SEL_A];
  wire        mem_mode = (mode == `BCMAE_M_SADDR) || (mode == `BCMAE_M_ABS) || (mode == `BCMAE_M_DE)
                      || (mode == `BCMAE_M_HL) || (mode == `BCMAE_M_HLB);
  wire        mem_rd  = ((grp == `BCMAE_GRP_TO_A || grp == `BCMAE_GRP_XCH || is_alu) && mem_mode)
                      || (is_word && mode == `BCMAE_W_LD);
  wire        mem_st  = ((grp == `BCMAE_GRP_FROM_A) && (mem_mode || mode == `BCMAE_M_IMM))
                      || (is_word && mode == `BCMAE_W_ST);
  wire        rmw     = is_alu && (mode == `BCMAE_M_DE);

  assign word_accumulator_pair = {regs[`BCMAE_SEL_A], regs[`BCMAE_SEL_X]};

  reg [15:0] ea;

  always @* begin
    ea = 16'h0000;
    case (mode)
      `BCMAE_M_IMM, `BCMAE_M_SADDR: ea = saddr_map(sa_byte);
      `BCMAE_M_ABS:                 ea = {pm_rdata, b1};
      `BCMAE_M_DE:                  ea = is_alu ? saddr_map(sa_byte) : pair_rd(`BCMAE_RP_DE);
      `BCMAE_M_HL:                  ea = pair_rd(`BCMAE_RP_HL);
      `BCMAE_M_HLB:                 ea = pair_rd(`BCMAE_RP_HL) + {8'h00, pm_rdata};
      default:                      ea = 16'h0000;
    endcase
    // word accesses drop bit 0 so a pair never straddles an odd boundary
    if (is_word)
      ea = saddr_map(sa_byte) & 16'hfffe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic

  wire [7:0] alu_a = rmw ? dm_rdata : acc;
  wire [7:0] alu_b = (mode == `BCMAE_M_IMM || rmw) ? imm
                   : (mode == `BCMAE_M_REG) ? regs[rsel] : dm_rdata;
  wire [1:0] alu_op = (grp == `BCMAE_GRP_ADD)  ? `BCMAE_ALU_ADD
                    : (grp == `BCMAE_GRP_ADD_WITH_CARRY) ? `BCMAE_ALU_ADD_WITH_CARRY : `BCMAE_ALU_SUB;
  wire [7:0] alu_res;
  wire       alu_z;
  wire       alu_ac;
  wire       alu_cy;

  bcmae_alu u_alu (
    .a     (alu_a),
    .b     (alu_b),
    .cin   (program_status_word[`BCMAE_PSW_CY]),
    .op    (alu_op),
    .res   (alu_res),
    .zero  (alu_z),
    .aux   (alu_ac),
    .carry (alu_cy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and execution

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pc                  <= `BCMAE_PC_RESET;
      pm_addr             <= `BCMAE_PC_RESET;
      cyc                 <= 4'h0;
      opcode              <= `BCMAE_OP_NOP;
      b1                  <= 8'h00;
      b2                  <= 8'h00;
      dm_addr             <= 16'h0000;
      dm_rd               <= 1'b0;
      dm_wr               <= 1'b0;
      dm_wdata            <= 8'h00;
      instr_done          <= 1'b0;
      bad_opcode          <= 1'b0;
      program_status_word <= `BCMAE_PSW_RESET;
      for (i = 0; i < 8; i = i + 1)
        regs[i] <= `BCMAE_REG_RESET;
    end else begin
      dm_rd      <= 1'b0;
      dm_wr      <= 1'b0;
      instr_done <= 1'b0;
      bad_opcode <= 1'b0;
      cyc        <= cyc + 4'h1;

      // fetch runs ahead sequentially; unused bytes are just dropped
      if (cyc == 4'h0)
        pm_addr <= pc + 16'h0001;
      if (cyc == `BCMAE_CYC_OPC) begin
        opcode  <= pm_rdata;
        pm_addr <= pc + 16'h0002;
      end
      if (cyc == `BCMAE_CYC_B1)
        b1 <= pm_rdata;
      if (cyc == `BCMAE_CYC_B2)
        b2 <= pm_rdata;

      // memory phase: address out, stores go with it
      if (legal && cyc == t_iss) begin
        if (mem_rd || mem_st)
          dm_addr <= ea;
        if (mem_rd)
          dm_rd <= 1'b1;
        if (mem_st) begin
          dm_wr <= 1'b1;
          if (is_word)
            dm_wdata <= regs[`BCMAE_SEL_X];
          else if (mode == `BCMAE_M_IMM)
            dm_wdata <= pm_rdata;
          else
            dm_wdata <= acc;
        end
      end

      // execute phase: read data is on dm_rdata now
      if (legal && cyc == t_exe) begin
        case (grp)
          `BCMAE_GRP_TO_A: begin
            if (mode == `BCMAE_M_IMM)
              regs[rsel] <= b2;
            else if (mode == `BCMAE_M_REG)
              regs[`BCMAE_SEL_A] <= regs[rsel];
            else if (mode == `BCMAE_M_PSW)
              regs[`BCMAE_SEL_A] <= program_status_word;
            else
              regs[`BCMAE_SEL_A] <= dm_rdata;
          end
          `BCMAE_GRP_FROM_A: begin
            if (mode == `BCMAE_M_REG)
              regs[rsel] <= acc;
            else if (mode == `BCMAE_M_PSW)
              program_status_word <= acc;
          end
          `BCMAE_GRP_XCH: begin
            if (mode == `BCMAE_M_IMM) begin
              regs[`BCMAE_SEL_A] <= regs[`BCMAE_SEL_X];
              regs[`BCMAE_SEL_X] <= acc;
            end else if (mode == `BCMAE_M_REG) begin
              regs[`BCMAE_SEL_A] <= regs[rsel];
              regs[rsel]         <= acc;
            end else begin
              regs[`BCMAE_SEL_A] <= dm_rdata;
              dm_wdata           <= acc;
              dm_wr              <= 1'b1;
            end
          end
          `BCMAE_GRP_ADD, `BCMAE_GRP_ADD_WITH_CARRY, `BCMAE_GRP_SUB: begin
            if (rmw) begin
              dm_wdata <= alu_res;
              dm_wr    <= 1'b1;
            end else begin
              regs[`BCMAE_SEL_A] <= alu_res;
            end
            program_status_word[`BCMAE_PSW_Z]  <= alu_z;
            program_status_word[`BCMAE_PSW_AC] <= alu_ac;
            program_status_word[`BCMAE_PSW_CY] <= alu_cy;
          end
          `BCMAE_GRP_WORD: begin
            case (mode)
              `BCMAE_W_IMM: begin
                regs[{rps, 1'b0}] <= b1;
                regs[{rps, 1'b1}] <= b2;
              end
              `BCMAE_W_LD: begin
                regs[`BCMAE_SEL_X] <= dm_rdata;
                dm_addr            <= {dm_addr[15:1], 1'b1};
                dm_rd              <= 1'b1;
              end
              `BCMAE_W_ST: begin
                dm_addr  <= {dm_addr[15:1], 1'b1};
                dm_wdata <= acc;
                dm_wr    <= 1'b1;
              end
              `BCMAE_W_FROM: begin
                regs[`BCMAE_SEL_X] <= regs[{rps, 1'b0}];
                regs[`BCMAE_SEL_A] <= regs[{rps, 1'b1}];
              end
              `BCMAE_W_TO: begin
                regs[{rps, 1'b0}] <= regs[`BCMAE_SEL_X];
                regs[{rps, 1'b1}] <= acc;
              end
              `BCMAE_W_XCH: begin
                regs[`BCMAE_SEL_X] <= regs[{rps, 1'b0}];
                regs[`BCMAE_SEL_A] <= regs[{rps, 1'b1}];
                regs[{rps, 1'b0}]  <= regs[`BCMAE_SEL_X];
                regs[{rps, 1'b1}]  <= acc;
              end
              default: begin
                dm_rd <= 1'b0;
              end
            endcase
          end
          default: begin
            if (opcode == `BCMAE_OP_PSW_IMM)
              program_status_word <= b2;
          end
        endcase
      end

      // high byte of a word load
      if (legal && is_word && mode == `BCMAE_W_LD && cyc == t_exe + 4'h1)
        regs[`BCMAE_SEL_A] <= dm_rdata;

      // last cycle: step to the next instruction, last assignment wins over fetch
      if (last) begin
        cyc        <= 4'h0;
        pc         <= pc + {14'h0000, nbytes};
        pm_addr    <= pc + {14'h0000, nbytes};
        instr_done <= 1'b1;
        bad_opcode <= ~legal;
      end
    end
  end

endmodule // bcmae_core

`default_nettype wire

// *** include/bcmae_consts.vh ***
// constants of the byte-cpu move/add execution core
`ifndef BCMAE_CONSTS_VH
`define BCMAE_CONSTS_VH

// opcode groups, opcode[7:5]
`define BCMAE_GRP_TO_A    3'h0
`define BCMAE_GRP_FROM_A  3'h1
`define BCMAE_GRP_XCH     3'h2
`define BCMAE_GRP_ADD     3'h3
`define BCMAE_GRP_ADD_WITH_CARRY    3'h4
`define BCMAE_GRP_SUB     3'h5
`define BCMAE_GRP_WORD    3'h6
`define BCMAE_GRP_MISC    3'h7

// byte addressing modes, opcode[2:0]
`define BCMAE_M_IMM       3'h0
`define BCMAE_M_REG       3'h1
`define BCMAE_M_SADDR     3'h2
`define BCMAE_M_ABS       3'h3
`define BCMAE_M_DE        3'h4
`define BCMAE_M_HL        3'h5
`define BCMAE_M_HLB       3'h6
`define BCMAE_M_PSW       3'h7

// word sub-operations, opcode[2:0] of the word group; opcode[4:3] is the pair
`define BCMAE_W_IMM       3'h0
`define BCMAE_W_LD        3'h1
`define BCMAE_W_ST        3'h2
`define BCMAE_W_FROM      3'h3
`define BCMAE_W_TO        3'h4
`define BCMAE_W_XCH       3'h5

// whole opcodes of the misc group
`define BCMAE_OP_PSW_IMM  8'he0
`define BCMAE_OP_NOP      8'he1

// byte register selectors
`define BCMAE_SEL_X       3'h0
`define BCMAE_SEL_A       3'h1

// register pair selectors
`define BCMAE_RP_AX       2'h0
`define BCMAE_RP_DE       2'h2
`define BCMAE_RP_HL       2'h3

// alu operations
`define BCMAE_ALU_ADD     2'h0
`define BCMAE_ALU_ADD_WITH_CARRY    2'h1
`define BCMAE_ALU_SUB     2'h2

// instruction lengths and clock counts
`define BCMAE_B1          2'h1
`define BCMAE_B2          2'h2
`define BCMAE_B3          2'h3
`define BCMAE_C2          4'h2
`define BCMAE_C4          4'h4
`define BCMAE_C6          4'h6
`define BCMAE_C8          4'h8

// fetch / memory phase cycles
`define BCMAE_CYC_OPC     4'h1
`define BCMAE_CYC_B1      4'h2
`define BCMAE_CYC_B2      4'h3

// short direct window
`define BCMAE_SADDR_SPLIT 8'h20
`define BCMAE_SADDR_HIPG  8'hff
`define BCMAE_SADDR_LOPG  8'hfe

// status word bit positions and reset values
`define BCMAE_PSW_Z       6
`define BCMAE_PSW_AC      4
`define BCMAE_PSW_CY      0
`define BCMAE_PSW_RESET   8'h00
`define BCMAE_PC_RESET    16'h0000
`define BCMAE_REG_RESET   8'h00

`endif

// *** verilog/bcmae_alu.v ***
// byte adder / subtracter with zero, nibble carry and carry outputs
`timescale 1ns/1ps
`default_nettype none
`include "bcmae_consts.vh"

module bcmae_alu (
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire       cin,
  input  wire [1:0] op,
  output reg  [7:0] res,
  output reg        zero,
  output reg        aux,
  output reg        carry
);

  reg [8:0] full;
  reg [4:0] nib;

  always @* begin
    full = 9'h000;
    nib  = 5'h00;
    case (op)
      `BCMAE_ALU_ADD: begin
        full = {1'b0, a} + {1'b0, b};
        nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      end
      `BCMAE_ALU_ADD_WITH_CARRY: begin
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      end
      `BCMAE_ALU_SUB: begin
        // bit 8 of the difference is the borrow
        full = {1'b0, a} - {1'b0, b};
        nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
      end
      default: begin
        full = {1'b0, a};
        nib  = 5'h00;
      end
    endcase
    res   = full[7:0];
    zero  = (full[7:0] == 8'h00);
    aux   = nib[4];
    carry = full[8];
  end

endmodule // bcmae_alu

`default_nettype wire

// *** test/bcmae_mem_model.sv ***
// program and data memory partner model for the byte cpu core
`timescale 1ns/1ps
`default_nettype none
module bcmae_mem (
  input  wire logic        clk,
  input  wire logic [15:0] pm_addr,
  output var  logic [7:0]  pm_rdata,
  input  wire logic [15:0] dm_addr,
  input  wire logic        dm_rd,
  input  wire logic        dm_wr,
  input  wire logic [7:0]  dm_wdata,
  output wire logic [7:0]  dm_rdata
);
  logic [7:0] pm [0:65535];
  logic [7:0] dm [0:65535];
  logic [7:0] idle_rdata = 8'h00;
  initial begin
    pm_rdata = 8'h00;
  end
  // core takes read data at the edge that ends its strobe cycle, so a read answers at once
  // idle read data flips each cycle so a misplaced sample never matches by luck
  assign dm_rdata = dm_rd ? dm[dm_addr] : idle_rdata;
  always @(posedge clk) begin
    pm_rdata <= #1 pm[pm_addr];
    idle_rdata <= #1 ~idle_rdata;
    if (dm_wr) begin
      dm[dm_addr] <= dm_wdata;
    end
  end
endmodule  // bcmae_mem
`default_nettype wire

// *** test/bcmae_core_properties.sv ***
// checker for the byte cpu core: bus timing, word pairing and status flags
`timescale 1ns/1ps
`default_nettype none
module bcmae_core_properties (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [15:0] pm_addr,
  input wire logic [7:0]  pm_rdata,
  input wire logic [15:0] dm_addr,
  input wire logic        dm_rd,
  input wire logic        dm_wr,
  input wire logic [7:0]  dm_wdata,
  input wire logic [7:0]  dm_rdata,
  input wire logic        instr_done,
  input wire logic        bad_opcode,
  input wire logic [15:0] word_accumulator_pair,
  input wire logic [7:0]  program_status_word
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  status_hold_a: assert property ($changed(program_status_word) |-> ##[0:3] instr_done)
    else $error("status word changed away from an instruction end");
  done_pulse_a: assert property (instr_done |=> !instr_done)
    else $error("completion pulse longer than one cycle");
  done_gap_a: assert property (instr_done |-> ##[2:8] instr_done)
    else $error("instruction ran past eight clocks");
  fetch_step_a: assert property (instr_done |=> pm_addr == $past(pm_addr) + 16'h0001)
    else $error("second fetch not at next byte");
  word_pair_a: assert property (dm_wr ##1 dm_wr |-> dm_addr[0] && dm_addr == $past(dm_addr) + 16'h0001)
    else $error("word store not even then odd");
  word_window_a: assert property (dm_wr ##1 dm_wr |-> dm_addr >= 16'hfe21 && dm_addr <= 16'hff1f)
    else $error("word store outside short direct window");
  word_data_a: assert property (dm_wr ##1 dm_wr |->
    dm_wdata == word_accumulator_pair[15:8] && $past(dm_wdata) == word_accumulator_pair[7:0])
    else $error("word store halves out of order");
  exch_swap_a: assert property (dm_rd ##1 (dm_wr && !instr_done) ##1 !instr_done |->
    dm_wdata == $past(word_accumulator_pair[15:8], 2) && word_accumulator_pair[15:8] == $past(dm_rdata, 2))
    else $error("exchange did not swap accumulator and memory");
  reset_state_a: assert property ($past(reset) |->
    pm_addr == 16'h0000 && word_accumulator_pair == 16'h0000 && program_status_word == 8'h00)
    else $error("state after reset not cleared");
  cover property (dm_wr ##1 dm_wr);
  cover property (bad_opcode);
  cover property (dm_rd ##1 (dm_wr && !instr_done) ##1 !instr_done);
endmodule  // bcmae_core_properties
bind bcmae_core bcmae_core_properties bcmae_core_properties_inst (.clk, .reset, .pm_addr, .pm_rdata,
  .dm_addr, .dm_rd, .dm_wr, .dm_wdata, .dm_rdata, .instr_done, .bad_opcode, .word_accumulator_pair,
  .program_status_word);
`default_nettype wire

// *** test/bcmae_core_tb.sv ***
// self-checking bench for the byte cpu move/add execution core
`timescale 1ns/1ps
`default_nettype none
`include "bcmae_consts.vh"
module bcmae_core_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  wire  [15:0] pm_addr, dm_addr, word_accumulator_pair;
  wire  [7:0]  pm_rdata, dm_rdata, dm_wdata, program_status_word;
  wire         dm_rd, dm_wr, instr_done, bad_opcode;
  int          n_fail = 0, n_tests = 0, cyc = -1, pc, i;
  logic [28:0] exp_q [$];
  logic [23:0] wr_q [$];
  logic [7:0]  r [0:7];
  logic [7:0]  st;
  always #20 clk = ~clk;
  bcmae_core bcmae_core_inst (.clk, .reset, .pm_addr, .pm_rdata, .dm_addr, .dm_rd, .dm_wr, .dm_wdata,
    .dm_rdata, .instr_done, .bad_opcode, .word_accumulator_pair, .program_status_word);
  bcmae_mem bcmae_mem_inst (.clk, .pm_addr, .pm_rdata, .dm_addr, .dm_rd, .dm_wr, .dm_wdata, .dm_rdata);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic emit(input int n, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    bcmae_mem_inst.pm[pc] = b0;
    bcmae_mem_inst.pm[pc+1] = b1;
    bcmae_mem_inst.pm[pc+2] = b2;
    pc += n;
  endtask
  task automatic done(input logic [3:0] clocks, input logic bad);
    exp_q.push_back({clocks, bad, r[1], r[0], st});
  endtask
  function automatic logic [7:0] alu(input logic [1:0] op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    logic       ci;
    ci = (op == `BCMAE_ALU_ADD_WITH_CARRY) & st[0];
    if (op == `BCMAE_ALU_SUB) begin
      s = {1'b0, a} - {1'b0, b};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    end else begin
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    end
    st[6] = (s[7:0] == 8'h00);
    st[4] = h[4];
    st[0] = s[8];
    return s[7:0];
  endfunction
  ////////////////////////////////////////
  // program and expectations are laid down while reset holds the core
  task automatic build();
    logic [7:0]  v, m, o;
    logic [15:0] a, ptr;
    logic [2:0]  k, g;
    pc = 0;
    st = 8'h00;
    for (int j = 0; j < 8; j++) r[j] = 8'h00;
    for (int j = 0; j < 256; j++) bcmae_mem_inst.pm[j] = `BCMAE_OP_NOP;
    for (int j = 0; j < 8; j++) begin
      k = 3'(j);
      v = 8'($urandom);
      emit(3, 8'h00, {5'h00, k}, v);
      r[k] = v;
      done(4'h6, 1'b0);
    end
    for (int j = 1; j < 4; j++) begin
      emit(1, {3'h6, 2'(j), `BCMAE_W_FROM}, 8'h00, 8'h00);
      r[0] = r[2*j];
      r[1] = r[2*j+1];
      done(4'h4, 1'b0);
    end
    // first pass forces zero with carry, then a borrow; second pass uses registers
    for (int j = 0; j < 6; j++) begin
      g = 3'(3 + j % 3);
      k = 3'(2 + $urandom % 6);
      v = (j == 0) ? 8'h00 - r[1] : (j == 2) ? r[1] + 8'h01 : 8'($urandom);
      emit(2, {g, 4'h0, j >= 3}, (j < 3) ? v : {5'h00, k}, 8'h00);
      r[1] = alu(2'(j % 3), r[1], (j < 3) ? v : r[k]);
      done(4'h4, 1'b0);
    end
    for (int j = 0; j < 3; j++) begin
      o = (j == 0) ? 8'h20 : (j == 1) ? 8'h1f : 8'h80 | 8'($urandom);
      a = {(o < 8'h20) ? 8'hff : 8'hfe, o};
      m = 8'($urandom);
      v = 8'($urandom);
      bcmae_mem_inst.dm[a] = m;
      emit(3, {3'(3 + j), 5'h04}, o, v);
      wr_q.push_back({a, alu(2'(j), m, v)});
      done(4'h6, 1'b0);
    end
    ptr = {2'b01, 14'($urandom)};
    emit(3, {3'h6, `BCMAE_RP_HL, `BCMAE_W_IMM}, ptr[7:0], ptr[15:8]);
    r[6] = ptr[7:0];
    r[7] = ptr[15:8];
    done(4'h6, 1'b0);
    for (int j = 0; j < 4; j++) begin
      o = {2'(j), 6'($urandom)};
      a = ptr + {8'h00, o};
      m = 8'($urandom);
      bcmae_mem_inst.dm[a] = m;
      if (j == 0) emit(2, 8'h06, o, 8'h00);
      if (j == 1) emit(2, 8'h66, o, 8'h00);
      if (j == 2) emit(2, 8'h46, o, 8'h00);
      if (j == 3) emit(2, 8'h26, o, 8'h00);
      if (j >= 2) wr_q.push_back({a, r[1]});
      r[1] = (j == 1) ? alu(`BCMAE_ALU_ADD, r[1], m) : (j == 3) ? r[1] : m;
      done((j == 2) ? 4'h8 : 4'h6, 1'b0);
    end
    for (int j = 0; j < 2; j++) begin
      a = j ? 16'h0000 : 16'hffff;
      m = 8'($urandom);
      bcmae_mem_inst.dm[a] = m;
      emit(3, j ? 8'ha3 : 8'h83, a[7:0], a[15:8]);
      r[1] = alu(j ? `BCMAE_ALU_SUB : `BCMAE_ALU_ADD_WITH_CARRY, r[1], m);
      done(4'h8, 1'b0);
    end
    // odd short word address rounds down to the even pair
    emit(2, 8'hc2, 8'h21, 8'h00);
    wr_q.push_back({16'hfe20, r[0]});
    wr_q.push_back({16'hfe21, r[1]});
    done(4'h8, 1'b0);
    v = r[0];
    m = r[1];
    emit(1, {3'h6, `BCMAE_RP_HL, `BCMAE_W_FROM}, 8'h00, 8'h00);
    r[0] = r[6];
    r[1] = r[7];
    done(4'h4, 1'b0);
    emit(2, 8'hc1, 8'h21, 8'h00);
    r[0] = v;
    r[1] = m;
    done(4'h6, 1'b0);
    // byte swap, status load and read-back, pair exchange
    emit(1, 8'h40, 8'h00, 8'h00);
    v = r[0];
    r[0] = r[1];
    r[1] = v;
    done(4'h4, 1'b0);
    st = 8'($urandom);
    emit(3, `BCMAE_OP_PSW_IMM, 8'h00, st);
    done(4'h6, 1'b0);
    emit(2, 8'h07, 8'h00, 8'h00);
    r[1] = st;
    done(4'h4, 1'b0);
    emit(1, {3'h6, `BCMAE_RP_DE, `BCMAE_W_XCH}, 8'h00, 8'h00);
    {r[5], r[4], r[1], r[0]} = {r[1], r[0], r[5], r[4]};
    done(4'h8, 1'b0);
    emit(1, `BCMAE_OP_NOP, 8'h00, 8'h00);
    done(4'h2, 1'b0);
    emit(1, 8'hff, `BCMAE_OP_NOP, `BCMAE_OP_NOP);
    done(4'h2, 1'b1);
  endtask
  ////////////////////////////////////////
  always @(negedge clk) begin
    cyc = reset ? -1 : cyc + 1;
    if (!reset && instr_done) begin
      if (exp_q.size() > 0) chk({3'h0, cyc[3:0], bad_opcode, word_accumulator_pair, program_status_word},
        {3'h0, exp_q.pop_front()});
      cyc = 0;
    end
    if (!reset && dm_wr) chk({8'h00, dm_addr, dm_wdata},
      (wr_q.size() > 0) ? {8'h00, wr_q.pop_front()} : 32'hffff_ffff);
  end
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic run(input int hold);
    build();
    repeat (hold) @(posedge clk);
    #1 reset = 1'b0;
    for (i = 0; i < 3000 && (exp_q.size() + wr_q.size()) > 0; i++) @(posedge clk);
    if ((exp_q.size() + wr_q.size()) > 0) begin
      n_fail++;
      close_out();
    end
    $display("program pass ended, %0d checks so far", n_tests);
    @(posedge clk);
    #1 reset = 1'b1;
  endtask
  // second pass resets a running core, so restart state is checked too
  initial begin
    void'($urandom(12993));
    run(6);
    run(2);
    close_out();
  end
endmodule  // bcmae_core_tb
`default_nettype wire
